// *** rtl/csc_pkg.sv ***
// constants, register map and carrier types of the clock source control
// assumes a classic wishbone master on clk_i; one 32-bit word per register
// How it works
// - no direct step between two settings of 43 MHz or above
// - 3..48 MHz via 6-bit table code
// - factory trims loaded at startup, readable
// - reset runs main oscillator at 24 MHz
// - spread mode: off, triangle, lfsr, routed input
// - spread range 1%, 2%, 4%, 3 reserved
// - spread only ever lowers the frequency
// - max count bounds counters, lengthens triangle
// - spread logic stepped by peripheral clock 0
// - 36 MHz output only for flash programming
// - low-speed oscillator enable bit
// - low-speed oscillator off in hibernate, stop
// - hf mux: external, divided crystal, main
// - lf mux: watch crystal or low-speed
// - crystal clock divided before hf mux
// - always start on main oscillator
// - ten 16-bit, two fractional dividers, sixteen clocks
// - prescaler derives system clock from hf
// - hf select 0 main, 1 ext, 2 crystal
// - lf select 0 low-speed, 1 watch crystal
// - crystal divider 1, 2, 4, 8
// - prescaler divides by two to the n
package csc_pkg;

  // byte offsets
  localparam logic [7:0] CSC_FREQ_CODE_OFS = 8'h00;
  localparam logic [7:0] CSC_FINE_TRIM_OFS = 8'h04;
  localparam logic [7:0] CSC_BG_TRIM_A_OFS = 8'h08;
  localparam logic [7:0] CSC_BG_TRIM_B_OFS = 8'h0c;
  localparam logic [7:0] CSC_SPREAD_OFS = 8'h10;
  localparam logic [7:0] CSC_LSO_CFG_OFS = 8'h14;
  localparam logic [7:0] CSC_SELECT_OFS = 8'h18;
  localparam logic [7:0] CSC_STATUS_OFS = 8'h1c;

  // spread control field positions
  localparam int CSC_SS_MODE_LSB = 0;
  localparam int CSC_SS_RANGE_LSB = 4;
  localparam int CSC_SS_MAX_LSB = 8;
  // select register field positions
  localparam int CSC_HF_SEL_LSB = 0;
  localparam int CSC_LF_SEL_LSB = 4;
  localparam int CSC_XDIV_LSB = 8;
  localparam int CSC_SYSDIV_LSB = 12;

  // reset values, code thresholds and range spans
  localparam logic [5:0] CSC_CODE_24MHZ = 6'h19;
  localparam logic [5:0] CSC_CODE_43MHZ = 6'h30;
  localparam logic [5:0] CSC_CODE_48MHZ = 6'h35;
  localparam logic [7:0] CSC_SS_MAX_RST = 8'hff;
  localparam logic [15:0] CSC_LFSR_SEED = 16'hace1;
  localparam logic [7:0] CSC_RANGE_1PCT = 8'h01;
  localparam logic [7:0] CSC_RANGE_2PCT = 8'h02;
  localparam logic [7:0] CSC_RANGE_4PCT = 8'h04;

  // peripheral divider counts
  localparam int CSC_NUM_INT_DIV = 10;
  localparam int CSC_NUM_FRAC_DIV = 2;
  localparam int CSC_NUM_PERI_CLK = 16;

  // settle time between code and trim steps
  localparam int CSC_SETTLE_NS = 5000;
  localparam int CSC_CLK_NS = 8;
  localparam int CSC_SETTLE_CYC = (CSC_SETTLE_NS + CSC_CLK_NS - 1) / CSC_CLK_NS;

  typedef enum logic [1:0] {
    CSC_SS_OFF = 2'b00,
    CSC_SS_TRI = 2'b01,
    CSC_SS_LFSR = 2'b10,
    CSC_SS_EXT = 2'b11
  } csc_ss_mode_t;

  typedef enum logic [2:0] {
    CSC_HF_MAIN = 3'b000,
    CSC_HF_EXT = 3'b001,
    CSC_HF_XTAL = 3'b010
  } csc_hf_sel_t;

  typedef struct packed {
    logic [5:0] freq_code;
    logic [7:0] fine_trim;
    logic [7:0] bg_trim_a;
    logic [7:0] bg_trim_b;
  } csc_trim_t;

  typedef struct packed {
    logic [1:0] hf_sel;
    logic lf_sel;
    logic [1:0] xtal_div;
    logic [2:0] sys_div;
  } csc_mux_t;

endpackage

// *** rtl/csc_clock_ctrl.sv ***
// clock source selection, main oscillator control and spread modulation
// assumes classic wishbone master on clk_i; clock selects are levels
// that drive analog muxes and dividers outside this block
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module csc_clock_ctrl (
  input wire logic clk_i, // 125 MHz bus clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic wb_we_i, // write enable
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o, // unmapped address
  input wire logic [29:0] factory_trim_i, // trims from supervisory flash
  input wire logic factory_valid_i, // trims ready pulse (clk domain)
  input wire logic peri_clk0_i, // peripheral clock 0, async
  input wire logic spread_in_i, // routed spread input, async
  input wire logic low_power_off_i, // hibernate or stop, async
  output logic [5:0] main_osc_freq_code_o, // oscillator frequency code
  output logic [7:0] main_osc_fine_trim_o, // oscillator trim
  output logic [7:0] bandgap_trim_a_o, // bandgap trim a
  output logic [7:0] bandgap_trim_b_o, // bandgap trim b
  output logic [7:0] spread_offset_o, // downward trim offset
  output logic prog_clk_en_o, // 36 MHz flash clock enable
  output logic low_speed_osc_en_o, // low-speed oscillator on
  output logic [2:0] hf_source_o, // hf mux select
  output logic lf_source_o, // lf mux select
  output logic [1:0] crystal_div_o, // crystal divider exponent
  output logic [2:0] clock_divide_field_o // prescaler exponent
);

  ////////////////////////////////////////////////////////////////////
  csc_pkg::csc_trim_t trim_reg;
  csc_pkg::csc_mux_t mux_reg;
  logic [1:0] ss_mode_reg;
  logic [1:0] ss_range_reg;
  logic [7:0] ss_max_reg;
  logic lso_en_reg;
  logic [12:0] settle_reg;
  logic boot_done_reg;
  logic [2:0] pclk_sync_reg;
  logic [1:0] sin_sync_reg;
  logic [1:0] lpo_sync_reg;
  logic [7:0] ss_cnt_reg;
  logic ss_dir_reg;
  logic [15:0] lfsr_reg;
  logic [7:0] ss_pos;
  logic [15:0] ss_prod;
  logic [31:0] ss_word;
  logic [31:0] ss_wr_word;
  logic pclk_rise;
  logic wr;
  logic rd;
  logic hit;

  // legal 3..48 MHz table entry; unused codes are rejected
  function automatic logic code_ok(input logic [5:0] c);
    code_ok = (c >= 6'h03) && (c <= csc_pkg::CSC_CODE_48MHZ) &&
      (c != 6'h0d) && (c != 6'h1a) && (c != 6'h24) && (c != 6'h2c) &&
      (c != 6'h2d);
  endfunction

  // top band where a direct jump between two codes is unsafe
  function automatic logic code_high(input logic [5:0] c);
    code_high = (c >= csc_pkg::CSC_CODE_43MHZ);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait-free answer, ack one cycle after request
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always_comb begin
    hit = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= csc_pkg::CSC_STATUS_OFS);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= rd && hit;
      wb_err_o <= rd && !hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd && hit) begin
      case (wb_adr_i)
        csc_pkg::CSC_FREQ_CODE_OFS: wb_dat_o <= {26'h0, trim_reg.freq_code};
        csc_pkg::CSC_FINE_TRIM_OFS: wb_dat_o <= {24'h0, trim_reg.fine_trim};
        csc_pkg::CSC_BG_TRIM_A_OFS: wb_dat_o <= {24'h0, trim_reg.bg_trim_a};
        csc_pkg::CSC_BG_TRIM_B_OFS: wb_dat_o <= {24'h0, trim_reg.bg_trim_b};
        csc_pkg::CSC_SPREAD_OFS: wb_dat_o <= ss_word;
        csc_pkg::CSC_LSO_CFG_OFS: wb_dat_o <= {31'h0, lso_en_reg};
        csc_pkg::CSC_SELECT_OFS: wb_dat_o <= {17'h0, mux_reg.sys_div, 2'h0,
          mux_reg.xtal_div, 3'h0, mux_reg.lf_sel, 2'h0, mux_reg.hf_sel};
        csc_pkg::CSC_STATUS_OFS: wb_dat_o <= {16'h0, spread_offset_o,
          5'h0, (settle_reg != 13'h0), lpo_sync_reg[1], boot_done_reg};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // oscillator code and trims; a write inside the settle window is
  // dropped, since trims and code must never move together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_reg.freq_code <= csc_pkg::CSC_CODE_24MHZ;
      trim_reg.fine_trim <= 8'h00;
      trim_reg.bg_trim_a <= 8'h00;
      trim_reg.bg_trim_b <= 8'h00;
      boot_done_reg <= 1'b0;
      settle_reg <= 13'h0000;
    end else begin
      if (settle_reg != 13'h0000) begin
        settle_reg <= settle_reg - 13'h0001;
      end
      if (factory_valid_i && !boot_done_reg) begin
        trim_reg.fine_trim <= factory_trim_i[7:0];
        trim_reg.bg_trim_a <= factory_trim_i[15:8];
        trim_reg.bg_trim_b <= factory_trim_i[23:16];
        if (code_ok(factory_trim_i[29:24])) begin
          trim_reg.freq_code <= factory_trim_i[29:24];
        end
        boot_done_reg <= 1'b1;
      end else if (wr && settle_reg == 13'h0000) begin
        case (wb_adr_i)
          csc_pkg::CSC_FREQ_CODE_OFS: begin
            // high-to-high jumps are refused; go via 24 MHz
            if (wb_sel_i[0] && code_ok(wb_dat_i[5:0]) &&
                !(code_high(wb_dat_i[5:0]) &&
                  code_high(trim_reg.freq_code))) begin
              trim_reg.freq_code <= wb_dat_i[5:0];
              settle_reg <= 13'(csc_pkg::CSC_SETTLE_CYC);
            end
          end
          csc_pkg::CSC_FINE_TRIM_OFS: begin
            if (wb_sel_i[0]) begin
              trim_reg.fine_trim <= wb_dat_i[7:0];
              settle_reg <= 13'(csc_pkg::CSC_SETTLE_CYC);
            end
          end
          csc_pkg::CSC_BG_TRIM_A_OFS: begin
            if (wb_sel_i[0]) begin
              trim_reg.bg_trim_a <= wb_dat_i[7:0];
            end
          end
          csc_pkg::CSC_BG_TRIM_B_OFS: begin
            if (wb_sel_i[0]) begin
              trim_reg.bg_trim_b <= wb_dat_i[7:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // spread, low-speed and mux configuration
  // spread word as software sees it, and with written lanes merged
  always_comb begin
    ss_word = {16'h0, ss_max_reg, 2'h0, ss_range_reg, 2'h0, ss_mode_reg};
    ss_wr_word = merge(ss_word, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_mode_reg <= csc_pkg::CSC_SS_OFF;
      ss_range_reg <= 2'b00;
      ss_max_reg <= csc_pkg::CSC_SS_MAX_RST;
    end else if (wr && wb_adr_i == csc_pkg::CSC_SPREAD_OFS) begin
      ss_mode_reg <= ss_wr_word[csc_pkg::CSC_SS_MODE_LSB +: 2];
      if (ss_wr_word[csc_pkg::CSC_SS_RANGE_LSB +: 2] != 2'b11) begin
        ss_range_reg <= ss_wr_word[csc_pkg::CSC_SS_RANGE_LSB +: 2];
      end
      ss_max_reg <= ss_wr_word[csc_pkg::CSC_SS_MAX_LSB +: 8];
    end
  end

  // enable resets on; the low-power pin gates it only at the output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lso_en_reg <= 1'b1;
    end else if (wr && wb_adr_i == csc_pkg::CSC_LSO_CFG_OFS &&
                 wb_sel_i[0]) begin
      lso_en_reg <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_reg.hf_sel <= 2'(csc_pkg::CSC_HF_MAIN);
      mux_reg.lf_sel <= 1'b0;
      mux_reg.xtal_div <= 2'b00;
      mux_reg.sys_div <= 3'b000;
    end else if (wr && wb_adr_i == csc_pkg::CSC_SELECT_OFS) begin
      // reserved selects leave the mux where it was
      if (wb_sel_i[0] && wb_dat_i[csc_pkg::CSC_HF_SEL_LSB +: 3] <=
          3'(csc_pkg::CSC_HF_XTAL)) begin
        mux_reg.hf_sel <= wb_dat_i[1:0];
      end
      if (wb_sel_i[0] &&
          wb_dat_i[csc_pkg::CSC_LF_SEL_LSB + 1 -: 2] <= 2'b01) begin
        mux_reg.lf_sel <= wb_dat_i[csc_pkg::CSC_LF_SEL_LSB];
      end
      if (wb_sel_i[1]) begin
        mux_reg.xtal_div <= wb_dat_i[csc_pkg::CSC_XDIV_LSB +: 2];
        mux_reg.sys_div <= wb_dat_i[csc_pkg::CSC_SYSDIV_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // async inputs; peripheral clock 0 is sampled, rising edges step the spread
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_sync_reg <= 3'b000;
      sin_sync_reg <= 2'b00;
      lpo_sync_reg <= 2'b00;
    end else begin
      pclk_sync_reg <= {pclk_sync_reg[1:0], peri_clk0_i};
      sin_sync_reg <= {sin_sync_reg[0], spread_in_i};
      lpo_sync_reg <= {lpo_sync_reg[0], low_power_off_i};
    end
  end
  // edge taken past the first stage, so a metastable value never steps
  assign pclk_rise = pclk_sync_reg[1] && !pclk_sync_reg[2];

  // triangle runs 0..max..0; lfsr and routed input also stay in 0..max
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_cnt_reg <= 8'h00;
      ss_dir_reg <= 1'b0;
      lfsr_reg <= csc_pkg::CSC_LFSR_SEED;
    end else if (pclk_rise) begin
      lfsr_reg <= {lfsr_reg[14:0],
        lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      case (ss_mode_reg)
        csc_pkg::CSC_SS_TRI: begin
          if (!ss_dir_reg) begin
            if (ss_cnt_reg >= ss_max_reg) begin
              ss_dir_reg <= 1'b1;
              ss_cnt_reg <= (ss_max_reg == 8'h00) ? 8'h00 : ss_max_reg - 8'h01;
            end else begin
              ss_cnt_reg <= ss_cnt_reg + 8'h01;
            end
          end else if (ss_cnt_reg == 8'h00) begin
            ss_dir_reg <= 1'b0;
            ss_cnt_reg <= (ss_max_reg == 8'h00) ? 8'h00 : 8'h01;
          end else begin
            ss_cnt_reg <= ss_cnt_reg - 8'h01;
          end
        end
        csc_pkg::CSC_SS_LFSR: begin
          ss_cnt_reg <= (lfsr_reg[7:0] > ss_max_reg) ?
            (lfsr_reg[7:0] & ss_max_reg) : lfsr_reg[7:0];
        end
        csc_pkg::CSC_SS_EXT: begin
          if (sin_sync_reg[1] && ss_cnt_reg < ss_max_reg) begin
            ss_cnt_reg <= ss_cnt_reg + 8'h01;
          end else if (!sin_sync_reg[1] && ss_cnt_reg != 8'h00) begin
            ss_cnt_reg <= ss_cnt_reg - 8'h01;
          end
        end
        default: begin
          ss_cnt_reg <= 8'h00;
          ss_dir_reg <= 1'b0;
        end
      endcase
    end
  end

  // offset = count/max * range units; subtracted below nominal only
  always_comb begin
    logic [7:0] span;
    span = 8'h00;
    case (ss_range_reg)
      2'b00: span = csc_pkg::CSC_RANGE_1PCT;
      2'b01: span = csc_pkg::CSC_RANGE_2PCT;
      2'b10: span = csc_pkg::CSC_RANGE_4PCT;
      default: span = 8'h00;
    endcase
    ss_prod = 16'(ss_cnt_reg) * 16'(span) * 16'h0010;
    // a count left above a freshly lowered max pins at full range
    ss_pos = 8'h00;
    if (ss_max_reg != 8'h00 && ss_cnt_reg >= ss_max_reg) begin
      ss_pos = {span[3:0], 4'h0};
    end else if (ss_max_reg != 8'h00) begin
      ss_pos = 8'(ss_prod / 16'(ss_max_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_osc_freq_code_o <= csc_pkg::CSC_CODE_24MHZ;
      main_osc_fine_trim_o <= 8'h00;
      bandgap_trim_a_o <= 8'h00;
      bandgap_trim_b_o <= 8'h00;
      spread_offset_o <= 8'h00;
      prog_clk_en_o <= 1'b0;
      low_speed_osc_en_o <= 1'b0;
      hf_source_o <= 3'(csc_pkg::CSC_HF_MAIN);
      lf_source_o <= 1'b0;
      crystal_div_o <= 2'b00;
      clock_divide_field_o <= 3'b000;
    end else begin
      main_osc_freq_code_o <= trim_reg.freq_code;
      main_osc_fine_trim_o <= trim_reg.fine_trim;
      bandgap_trim_a_o <= trim_reg.bg_trim_a;
      bandgap_trim_b_o <= trim_reg.bg_trim_b;
      spread_offset_o <= (ss_mode_reg == csc_pkg::CSC_SS_OFF) ?
        8'h00 : ss_pos;
      prog_clk_en_o <= boot_done_reg;
      low_speed_osc_en_o <= lso_en_reg && !lpo_sync_reg[1];
      hf_source_o <= {1'b0, mux_reg.hf_sel};
      lf_source_o <= mux_reg.lf_sel;
      crystal_div_o <= mux_reg.xtal_div;
      clock_divide_field_o <= mux_reg.sys_div;
    end
  end

endmodule

// *** verification/csc_clock_ctrl_props.sv ***
// port checker for the clock source control block
// assumes one clock domain, clk_i with synchronous reset rst_i
`timescale 1ns/10ps
module csc_clock_ctrl_props (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // acknowledge
  input wire logic wb_err_o, // error
  input wire logic low_power_off_i, // hibernate or stop
  input wire logic [5:0] main_osc_freq_code_o, // frequency code
  input wire logic [7:0] spread_offset_o, // spread offset
  input wire logic [2:0] hf_source_o, // hf select
  input wire logic low_speed_osc_en_o // low-speed enable
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("request not answered");
  no_resp_a: assert property (!(wb_cyc_i && wb_stb_i) |=>
    !wb_ack_o && !wb_err_o) else $error("answer without request");
  ack_one_a: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");
  rst_start_a: assert property ($fell(rst_i) |->
    main_osc_freq_code_o == csc_pkg::CSC_CODE_24MHZ && hf_source_o == 3'h0)
    else $error("wrong start after reset");
  code_max_a: assert property (main_osc_freq_code_o <= 6'h35)
    else $error("frequency code above top");
  code_table_a: assert property (main_osc_freq_code_o inside
    {[6'h03:6'h0c], [6'h0e:6'h19], [6'h1b:6'h23], [6'h25:6'h2b],
     [6'h2e:6'h35]}) else $error("frequency code not in table");
  hf_legal_a: assert property (hf_source_o <= 3'h2)
    else $error("reserved hf select");
  down_only_a: assert property (spread_offset_o <= 8'h40)
    else $error("spread offset beyond range");
  lso_off_a: assert property (low_power_off_i [*6] |->
    !low_speed_osc_en_o) else $error("low-speed osc on in low power");

  cover property (wb_ack_o);
  cover property (wb_err_o);
  cover property (spread_offset_o == 8'h40);
  cover property (!low_speed_osc_en_o);
endmodule

bind csc_clock_ctrl csc_clock_ctrl_props u_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .low_power_off_i(low_power_off_i),
  .main_osc_freq_code_o(main_osc_freq_code_o),
  .spread_offset_o(spread_offset_o),
  .hf_source_o(hf_source_o),
  .low_speed_osc_en_o(low_speed_osc_en_o)
);

// *** verification/tb_top.sv ***
// self-checking bench for the clock source control block
// assumes the bench is the only wishbone master; byte enables all set
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, er, prog_o, lso_o, lf_o;
  logic [29:0] factory_trim_i = 30'h0;
  logic factory_valid_i = 1'b0;
  logic peri_clk0_i = 1'b0;
  logic spread_in_i = 1'b0;
  logic low_power_off_i = 1'b0;
  logic [5:0] code_o;
  logic [7:0] fine_o, bga_o, bgb_o, ofs_o, pk;
  logic [2:0] hf_o, sd_o;
  logic [1:0] xd_o;
  int n_fail = 0;
  int num_checks = 0;

  always #4 clk_i = ~clk_i;

  csc_clock_ctrl dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .factory_trim_i(factory_trim_i),
    .factory_valid_i(factory_valid_i),
    .peri_clk0_i(peri_clk0_i),
    .spread_in_i(spread_in_i),
    .low_power_off_i(low_power_off_i),
    .main_osc_freq_code_o(code_o),
    .main_osc_fine_trim_o(fine_o),
    .bandgap_trim_a_o(bga_o),
    .bandgap_trim_b_o(bgb_o),
    .spread_offset_o(ofs_o),
    .prog_clk_en_o(prog_o),
    .low_speed_osc_en_o(lso_o),
    .hf_source_o(hf_o),
    .lf_source_o(lf_o),
    .crystal_div_o(xd_o),
    .clock_divide_field_o(sd_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ack is read before the edge's own updates, i.e. its sampled value
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      end_of_test();
    end
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // poll the busy flag; trims written while busy would be dropped
  task automatic settle();
    int k;
    for (k = 0; k < 800; k++) begin
      wb(8'h1c, 1'b0, 32'h0);
      if (rd[2] === 1'b0) break;
    end
    if (k == 800) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic spin(input int t);
    for (int i = 0; i < t; i++) begin
      repeat (4) @(posedge clk_i);
      peri_clk0_i <= ~peri_clk0_i;
      if (ofs_o > pk) pk = ofs_o;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(32'(code_o), 32'h19);
    chk(32'({hf_o, xd_o, sd_o}), 32'h0);
    chk(32'(prog_o), 32'h0);
    @(posedge clk_i);
    factory_trim_i <= {6'h23, 8'h66, 8'h3c, 8'h5a};
    factory_valid_i <= 1'b1;
    @(posedge clk_i);
    factory_valid_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(32'({code_o, fine_o, bga_o, bgb_o}), 32'h235a3c66);
    chk(32'({prog_o, lso_o}), 32'h3);
    settle();
    chk(rd & 32'h1, 32'h1);
    // lowering: code taken, the early trim write must bounce
    wb(8'h00, 1'b1, 32'h0c);
    wb(8'h04, 1'b1, 32'h11);
    @(negedge clk_i);
    chk(32'({code_o, fine_o}), 32'h0c5a);
    settle();
    wb(8'h04, 1'b1, 32'h11);
    settle();
    wb(8'h00, 1'b1, 32'h0d);
    settle();
    @(negedge clk_i);
    chk(32'({code_o, fine_o}), 32'h0c11);
    wb(8'h08, 1'b1, 32'h77);
    wb(8'h00, 1'b1, 32'h30);
    settle();
    chk(32'(bga_o), 32'h77);
    wb(8'h00, 1'b1, 32'h35);
    settle();
    chk(32'(code_o), 32'h30);
    for (int i = 0; i < 8; i++) begin
      wb(8'h18, 1'b1,
        32'(i << 12 | (i % 4) << 8 | (i % 2) << 4 | i % 3));
      @(negedge clk_i);
      chk(32'({sd_o, xd_o, lf_o, hf_o}),
        32'(i << 6 | (i % 4) << 4 | (i % 2) << 3 | i % 3));
    end
    wb(8'h18, 1'b1, 32'h7313);
    wb(8'h18, 1'b0, 32'h0);
    chk(rd & 32'h7313, 32'h7311);
    wb(8'h20, 1'b0, 32'h0);
    chk(32'(er), 32'h1);
    for (int r = 0; r < 3; r++) begin
      pk = 8'h0;
      wb(8'h10, 1'b1, 32'(32'h0401 | r << 4));
      spin(40);
      chk(32'(pk), 32'(16 << r));
    end
    wb(8'h10, 1'b1, 32'h0431);
    wb(8'h10, 1'b0, 32'h0);
    chk(rd & 32'h30, 32'h20);
    wb(8'h10, 1'b1, 32'h0422);
    spin(4);
    pk = 8'h0;
    spin(40);
    chk(32'(pk != 8'h0), 32'h1);
    spread_in_i <= 1'b1;
    wb(8'h10, 1'b1, 32'h0423);
    spin(40);
    @(negedge clk_i);
    chk(32'(ofs_o), 32'h40);
    wb(8'h10, 1'b1, 32'h0420);
    spin(8);
    chk(32'(ofs_o), 32'h0);
    wb(8'h14, 1'b1, 32'h0);
    @(negedge clk_i);
    chk(32'(lso_o), 32'h0);
    wb(8'h14, 1'b1, 32'h1);
    low_power_off_i <= 1'b1;
    repeat (8) @(negedge clk_i);
    chk(32'(lso_o), 32'h0);
    @(posedge clk_i);
    low_power_off_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk(32'(lso_o), 32'h1);
    end_of_test();
  end
endmodule
